// *** rtl/spc_pkg.sv ***
// package of the step pulse command decoder: register map, field layout,
// reset values and the pulse format codes.
// assumes a 32-bit APB with a 12-bit byte address.
package spc_pkg;

    // ****************************************************************
    // bus geometry
    // ****************************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ****************************************************************
    // register offsets (byte addresses)
    // ****************************************************************
    localparam logic [11:0] OFF_CFG    = 12'h000;
    localparam logic [11:0] OFF_ACTIVE = 12'h004;
    localparam logic [11:0] OFF_POS    = 12'h008;
    localparam logic [11:0] OFF_STAT   = 12'h00C;
    localparam logic [11:0] OFF_CTRL   = 12'h010;

    // ****************************************************************
    // setting field positions (CFG and ACTIVE share one layout)
    // ****************************************************************
    localparam int FLD_MODE_LO = 0;
    localparam int FLD_MODE_HI = 2;
    localparam int FLD_CON_NC  = 3;
    localparam int FLD_EXC_ZRO = 4;
    localparam int FLD_AUTORET = 5;
    localparam int FLD_POS_CW  = 6;

    // status fields
    localparam int FLD_EXCITED = 0;
    localparam int FLD_AT_ZERO = 1;
    localparam int FLD_RETURN  = 2;
    localparam int FLD_FIRST   = 3;

    // control fields
    localparam int FLD_RELOAD  = 0;

    // ****************************************************************
    // reset values of the settings
    // ****************************************************************
    localparam logic [2:0] RST_MODE    = 3'h0;
    localparam logic       RST_CON_NC  = 1'b0;
    localparam logic       RST_EXC_ZRO = 1'b0;
    localparam logic       RST_AUTORET = 1'b0;
    localparam logic       RST_POS_CW  = 1'b1;

    // ****************************************************************
    // pulse format codes
    // ****************************************************************
    typedef enum logic [2:0] {
        FMT_SWITCH  = 3'h0,
        FMT_DUAL_LO = 3'h1,
        FMT_DUAL_HI = 3'h2,
        FMT_ONE_LO  = 3'h3,
        FMT_ONE_HI  = 3'h4,
        FMT_QUAD_X1 = 3'h5,
        FMT_QUAD_X2 = 3'h6,
        FMT_QUAD_X4 = 3'h7
    } spc_fmt_type;

    // quadrature multiplier codes
    localparam logic [1:0] MUL_X1 = 2'h0;
    localparam logic [1:0] MUL_X2 = 2'h1;
    localparam logic [1:0] MUL_X4 = 2'h2;

endpackage

// *** rtl/spc_sync_line.sv ***
// two-stage synchroniser with history stage for the pulse input lines.
// assumes lines are asynchronous to mclk; one generate entry per line.
`timescale 1ns/1ps

module spc_sync_line
#(
    parameter int N = 2
)
(
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         nrst,
    // raw lines
    input  wire logic [N-1:0] rawLine,
    // synchronised level and its previous value
    output logic      [N-1:0] lineLvl,
    output logic      [N-1:0] linePrev
);

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_line
            logic meta_q;
            logic sync_q;
            logic prev_q;
            always_ff @(posedge mclk or negedge nrst)
            begin
                if (!nrst)
                begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    prev_q <= 1'b0;
                end
                else
                begin
                    meta_q <= rawLine[i];
                    sync_q <= meta_q;
                    prev_q <= sync_q;
                end
            end
            assign lineLvl[i]  = sync_q;
            assign linePrev[i] = prev_q;
        end
    endgenerate

endmodule // spc_sync_line

// *** rtl/spc_quad_dec.sv ***
// quadrature decoder: forward when line b lags line a by a quarter period.
// assumes levels are synchronised and already polarity corrected.
`timescale 1ns/1ps

module spc_quad_dec
    import spc_pkg::*;
(
    // current and previous levels
    input  wire logic       aLvl,
    input  wire logic       aPrev,
    input  wire logic       bLvl,
    input  wire logic       bPrev,
    // multiplier
    input  wire logic [1:0] mul,
    // step strobes
    output logic            stepUp,
    output logic            stepDn
);

    logic aEdge;
    logic bEdge;
    logic aFwd;
    logic bFwd;

    assign aEdge = aLvl ^ aPrev;
    assign bEdge = bLvl ^ bPrev;
    // a leads: a rises with b low, falls with b high
    assign aFwd  = aLvl ^ bLvl;
    // a leads: b rises with a high, falls with a low
    assign bFwd  = ~(bLvl ^ aLvl);

    always_comb
    begin
        stepUp = 1'b0;
        stepDn = 1'b0;
        // both lines moving at once is not a legal quadrature state
        if (!(aEdge && bEdge))
        begin
            unique case (mul)
                MUL_X1:
                begin
                    stepUp = aEdge && aLvl && !bLvl;
                    stepDn = aEdge && aLvl && bLvl;
                end
                MUL_X2:
                begin
                    stepUp = aEdge && aFwd;
                    stepDn = aEdge && !aFwd;
                end
                MUL_X4:
                begin
                    stepUp = (aEdge && aFwd) || (bEdge && bFwd);
                    stepDn = (aEdge && !aFwd) || (bEdge && !bFwd);
                end
                default:
                begin
                    stepUp = 1'b0;
                    stepDn = 1'b0;
                end
            endcase
        end
    end

endmodule // spc_quad_dec

// *** rtl/spc_decoder.sv ***
// top of the step pulse command decoder: APB settings, pulse decode,
// command position, rotation sense, excitation and automatic return.
// assumes APB master on mclk; rotor and deviation status from the motor side.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps

// What this block does
// - single-pulse: each step pulse moves one step in the direction line's sense.
// - dual-pulse: clockwise line steps forward, counter-clockwise line steps back.
// - quadrature: forward when second line lags first by quarter period.
// - format codes: 0 switch, 1-2 dual, 3-4 single, 5-7 quadrature x1/x2/x4.
// - settings take effect only after a power cycle, latched at power-up.
// - current-on active energises windings at detected rotor position by default.
// - zero-angle setting energises where the electrical zero output is active.
// - normally-closed current-on energises at electrical zero after power-up.
// - current-on polarity: 0 normally open, 1 normally closed, default 0.
// - first excitation position: 0 detected, 1 electrical zero, default 0.
// - automatic return drives motor back to zero deviation.
// - return starts at power-up, current-on rising, or shaft-release falling.
// - automatic return setting: 0 disabled, 1 enabled, default disabled.
// - clockwise-line pulse increments position, counter-clockwise decrements.
// - positive clockwise: increment turns clockwise; otherwise reversed.
// - rotation setting: 0 positive counter-clockwise, 1 clockwise, default 1.
module spc_decoder
    import spc_pkg::*;
#(
    parameter logic AC_VARIANT = 1'b1
)
(
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      nrst,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [spc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [spc_pkg::DATA_W-1:0] pwdata,
    output logic      [spc_pkg::DATA_W-1:0] prdata,
    output logic                           pready,
    output logic                           pslverr,
    // pulse lines and format switch
    input  wire logic                      cwLine,
    input  wire logic                      ccwLine,
    input  wire logic                      modeSwitch,
    // motor side status
    input  wire logic                      currentOn,
    input  wire logic                      freeIn,
    input  wire logic                      rotorAtZero,
    input  wire logic                      deviationZero,
    // motor commands
    output logic      [31:0]               cmdPos,
    output logic                           motorStepCw,
    output logic                           motorStepCcw,
    output logic                           exciteEn,
    output logic                           exciteAtZero,
    output logic                           autoReturn,
    output logic                           electricalZeroOutput
);

    // ****************************************************************
    // settings: pending (software) and active (latched at power-up)
    // ****************************************************************
    logic [6:0]  pendCfg_q;
    logic [2:0]  actMode_q;
    logic        actNc_q;
    logic        actZero_q;
    logic        actRet_q;
    logic        actPosCw_q;
    logic        powerUp_q;
    logic        wrEn;
    logic        rdEn;
    logic        reload;
    logic        addrOk;

    assign wrEn   = psel && penable && pwrite;
    assign rdEn   = psel && !penable && !pwrite;
    assign reload = wrEn && (paddr == OFF_CTRL) && pwdata[FLD_RELOAD];

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            pendCfg_q <= {RST_POS_CW, RST_AUTORET, RST_EXC_ZRO, RST_CON_NC, RST_MODE};
        else if (wrEn && (paddr == OFF_CFG))
            pendCfg_q <= pwdata[6:0];
    end

    // reload pulse stands for a power cycle of the driver
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            actMode_q  <= RST_MODE;
            actNc_q    <= RST_CON_NC;
            actZero_q  <= RST_EXC_ZRO;
            actRet_q   <= RST_AUTORET;
            actPosCw_q <= RST_POS_CW;
        end
        else if (reload)
        begin
            actMode_q  <= pendCfg_q[FLD_MODE_HI:FLD_MODE_LO];
            actNc_q    <= pendCfg_q[FLD_CON_NC];
            actZero_q  <= pendCfg_q[FLD_EXC_ZRO];
            actRet_q   <= pendCfg_q[FLD_AUTORET];
            actPosCw_q <= pendCfg_q[FLD_POS_CW];
        end
    end

    // one-cycle power-up marker after reset or reload
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            powerUp_q <= 1'b1;
        else
            powerUp_q <= reload;
    end

    // ****************************************************************
    // pulse decode
    // ****************************************************************
    spc_fmt_type fmt;
    logic [1:0]  lvl;
    logic [1:0]  prv;
    logic        lowAct;
    logic        aLvl;
    logic        aPrev;
    logic        bLvl;
    logic        bPrev;
    logic [1:0]  mul;
    logic        qUp;
    logic        qDn;
    logic        stepUp;
    logic        stepDn;

    spc_sync_line #(.N(2)) u_sync (
        .mclk     (mclk),
        .nrst     (nrst),
        .rawLine  ({ccwLine, cwLine}),
        .lineLvl  (lvl),
        .linePrev (prv)
    );

    // format 0 defers to the switch: high single, low dual
    always_comb
    begin
        if (actMode_q == FMT_SWITCH)
            fmt = modeSwitch ? FMT_ONE_HI : FMT_DUAL_HI;
        else
            fmt = spc_fmt_type'(actMode_q);
    end

    assign lowAct = (fmt == FMT_DUAL_LO) || (fmt == FMT_ONE_LO);
    assign aLvl   = lvl[0] ^ lowAct;
    assign aPrev  = prv[0] ^ lowAct;
    assign bLvl   = lvl[1] ^ lowAct;
    assign bPrev  = prv[1] ^ lowAct;

    always_comb
    begin
        unique case (fmt)
            FMT_QUAD_X2: mul = MUL_X2;
            FMT_QUAD_X4: mul = MUL_X4;
            default:     mul = MUL_X1;
        endcase
    end

    spc_quad_dec u_quad (
        .aLvl   (aLvl),
        .aPrev  (aPrev),
        .bLvl   (bLvl),
        .bPrev  (bPrev),
        .mul    (mul),
        .stepUp (qUp),
        .stepDn (qDn)
    );

    always_comb
    begin
        unique case (fmt)
            FMT_DUAL_LO, FMT_DUAL_HI:
            begin
                stepUp = aLvl && !aPrev && !(bLvl && !bPrev);
                stepDn = bLvl && !bPrev && !(aLvl && !aPrev);
            end
            FMT_ONE_LO, FMT_ONE_HI:
            begin
                stepUp = aLvl && !aPrev && bLvl;
                stepDn = aLvl && !aPrev && !bLvl;
            end
            FMT_QUAD_X1, FMT_QUAD_X2, FMT_QUAD_X4:
            begin
                stepUp = qUp;
                stepDn = qDn;
            end
            default:
            begin
                stepUp = 1'b0;
                stepDn = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // command position and rotation sense
    // ****************************************************************
    logic [31:0] pos_q;
    logic        stepCw_q;
    logic        stepCcw_q;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            pos_q <= 32'h0000_0000;
        else if (stepUp)
            pos_q <= pos_q + 32'h0000_0001;
        else if (stepDn)
            pos_q <= pos_q - 32'h0000_0001;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            stepCw_q  <= 1'b0;
            stepCcw_q <= 1'b0;
        end
        else
        begin
            stepCw_q  <= actPosCw_q ? stepUp : stepDn;
            stepCcw_q <= actPosCw_q ? stepDn : stepUp;
        end
    end

    // ****************************************************************
    // excitation and automatic return
    // ****************************************************************
    logic conAct;
    logic conPrev_q;
    logic freePrev_q;
    logic excite_q;
    logic atZero_q;
    logic firstDone_q;
    logic ret_q;
    logic zeroOut_q;
    logic retStart;

    assign conAct   = actNc_q ? !currentOn : currentOn;
    assign retStart = actRet_q && ((powerUp_q && AC_VARIANT) || (conAct && !conPrev_q)
                      || (!freeIn && freePrev_q));

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            conPrev_q  <= 1'b0;
            freePrev_q <= 1'b0;
            zeroOut_q  <= 1'b0;
        end
        else
        begin
            conPrev_q  <= conAct;
            freePrev_q <= freeIn;
            zeroOut_q  <= rotorAtZero;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            excite_q    <= 1'b0;
            atZero_q    <= 1'b0;
            firstDone_q <= 1'b0;
        end
        else if (powerUp_q)
        begin
            excite_q    <= 1'b0;
            atZero_q    <= 1'b0;
            firstDone_q <= 1'b0;
        end
        else
        begin
            // normally closed is active from power-up with no transition
            excite_q <= conAct && !freeIn;
            if (conAct && !freeIn && !excite_q && !firstDone_q)
            begin
                atZero_q    <= actZero_q || actNc_q;
                firstDone_q <= 1'b1;
            end
            else if (!conAct || freeIn)
                atZero_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            ret_q <= 1'b0;
        else if (retStart)
            ret_q <= 1'b1;
        else if (deviationZero || !actRet_q || freeIn)
            ret_q <= 1'b0;
    end

    // ****************************************************************
    // apb read path
    // ****************************************************************
    logic [31:0] rdata_q;

    assign addrOk = (paddr == OFF_CFG) || (paddr == OFF_ACTIVE) || (paddr == OFF_POS)
                    || (paddr == OFF_STAT) || (paddr == OFF_CTRL);

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            rdata_q <= 32'h0000_0000;
        else if (rdEn)
        begin
            unique case (paddr)
                OFF_CFG:    rdata_q <= {25'h0, pendCfg_q};
                OFF_ACTIVE: rdata_q <= {25'h0, actPosCw_q, actRet_q, actZero_q, actNc_q,
                                        actMode_q};
                OFF_POS:    rdata_q <= pos_q;
                OFF_STAT:   rdata_q <= {28'h0, firstDone_q, ret_q, atZero_q, excite_q};
                default:    rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata               = rdata_q;
    assign pready               = psel && penable;
    assign pslverr              = psel && penable && !addrOk;
    assign cmdPos               = pos_q;
    assign motorStepCw          = stepCw_q;
    assign motorStepCcw         = stepCcw_q;
    assign exciteEn             = excite_q;
    assign exciteAtZero         = atZero_q;
    assign autoReturn           = ret_q;
    assign electricalZeroOutput = zeroOut_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    posInc_a: assert property (@(posedge mclk) disable iff (!nrst)
        stepUp |=> pos_q == $past(pos_q) + 32'h0000_0001)
        else $error("position did not increment on forward step");
    posDec_a: assert property (@(posedge mclk) disable iff (!nrst)
        stepDn |=> pos_q == $past(pos_q) - 32'h0000_0001)
        else $error("position did not decrement on reverse step");
    dualStep_a: assert property (@(posedge mclk) disable iff (!nrst)
        (fmt == FMT_DUAL_HI) && lvl[0] && !prv[0] && !(lvl[1] && !prv[1]) |-> stepUp)
        else $error("dual-pulse forward edge not counted");
    singleDir_a: assert property (@(posedge mclk) disable iff (!nrst)
        (fmt == FMT_ONE_HI) && lvl[0] && !prv[0] |-> (stepUp == lvl[1]) && (stepUp != stepDn))
        else $error("single-pulse direction wrong");
    quadFwd_a: assert property (@(posedge mclk) disable iff (!nrst)
        (fmt == FMT_QUAD_X4) && !bLvl && !bPrev && aLvl && !aPrev |-> stepUp && !stepDn)
        else $error("quadrature forward edge not counted");
    rotSense_a: assert property (@(posedge mclk) disable iff (!nrst)
        stepUp |=> (stepCw_q == $past(actPosCw_q)) && (stepCcw_q != $past(actPosCw_q)))
        else $error("rotation sense does not follow setting");
    cfgHold_a: assert property (@(posedge mclk) disable iff (!nrst)
        !reload |=> $stable(actMode_q) && $stable(actRet_q) && $stable(actPosCw_q))
        else $error("active setting changed without power cycle");
    retStart_a: assert property (@(posedge mclk) disable iff (!nrst)
        actRet_q && conAct && !conPrev_q |=> ret_q)
        else $error("automatic return not started on current-on");
    retOff_a: assert property (@(posedge mclk) disable iff (!nrst)
        !actRet_q ##1 !actRet_q |-> !ret_q)
        else $error("automatic return while disabled");
    zeroExc_a: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(excite_q) && !$past(firstDone_q) && actZero_q |-> atZero_q)
        else $error("first excitation not at electrical zero");

endmodule // spc_decoder

// *** testbench/spc_pulse_gen.sv ***
// pulse generator model driving the two pulse lines of the decoder.
// assumes the bench calls unit() and sets the polarity bits between units.
`timescale 1ns/1ps

module spc_pulse_gen
(
    // clock
    input  wire logic mclk,
    // pulse lines
    output logic      cwLine,
    output logic      ccwLine
);
    logic a    = 1'b0;
    logic b    = 1'b0;
    logic invA = 1'b0;
    logic invB = 1'b0;
    assign cwLine  = a ^ invA;
    assign ccwLine = b ^ invB;

    // each level stands three cycles, above the two the decoder needs
    task automatic hold();
        repeat (3) @(posedge mclk);
    endtask

    // one unit: k 0 dual, 1 single, 2 one full quadrature cycle
    task automatic unit(input int k, input logic fwd);
        logic [7:0] s;
        s = fwd ? 8'hB4 : 8'h78;
        @(posedge mclk);
        if (k == 2)
        begin
            for (int i = 0; i < 4; i++)
            begin
                {a, b} <= s[7-2*i -: 2];
                hold();
            end
        end
        else if (k == 1)
        begin
            b <= fwd;
            hold();
            a <= 1'b1;
            hold();
            a <= 1'b0;
            hold();
            b <= 1'b0;
            hold();
        end
        else
        begin
            if (fwd) a <= 1'b1;
            else b <= 1'b1;
            hold();
            a <= 1'b0;
            b <= 1'b0;
            hold();
        end
    endtask
endmodule // spc_pulse_gen

// *** testbench/test_spc_decoder.sv ***
// self-checking bench of the step pulse command decoder.
// assumes zero-wait APB and the pulse generator model beside it.
`timescale 1ns/1ps

module test_spc_decoder;
    import spc_pkg::*;
    logic        mclk = 1'b0, nrst = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, cmdPos, base, q;
    logic        pready, pslverr, cwLine, ccwLine, modeSwitch = 1'b0;
    logic        currentOn = 1'b0, freeIn = 1'b0, rotorAtZero = 1'b0, deviationZero = 1'b0;
    logic        motorStepCw, motorStepCcw, exciteEn, exciteAtZero, autoReturn, elZero, err;
    int          n_mismatch = 0, cmp_count = 0, cntCw = 0, cntCcw = 0, bCw, bCcw, d, k;
    logic [31:0] prevAct = 32'h40, cfg;

    always #2 mclk = ~mclk;

    spc_decoder spc_decoder_inst (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cwLine(cwLine), .ccwLine(ccwLine), .modeSwitch(modeSwitch),
        .currentOn(currentOn), .freeIn(freeIn), .rotorAtZero(rotorAtZero),
        .deviationZero(deviationZero), .cmdPos(cmdPos), .motorStepCw(motorStepCw),
        .motorStepCcw(motorStepCcw), .exciteEn(exciteEn), .exciteAtZero(exciteAtZero),
        .autoReturn(autoReturn), .electricalZeroOutput(elZero));
    spc_pulse_gen spc_pulse_gen_inst (.mclk(mclk), .cwLine(cwLine), .ccwLine(ccwLine));

    always @(posedge mclk)
    begin
        if (motorStepCw === 1'b1) cntCw++;
        if (motorStepCcw === 1'b1) cntCcw++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] dt);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dt;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        apb(OFF_CFG, 1'b0, 0);
        chk(q, 32'h40);
        apb(12'h014, 1'b0, 0);
        chk({q[0], err}, 2'b01);
        for (int m = 0; m < 8; m++)
        begin
            cfg = {25'h0, m[0], 3'h0, m[2:0]};
            apb(OFF_CFG, 1'b1, cfg);
            apb(OFF_ACTIVE, 1'b0, 0);
            chk(q, prevAct);
            spc_pulse_gen_inst.invA <= (m == 1 || m == 3);
            spc_pulse_gen_inst.invB <= (m == 1 || m == 3);
            apb(OFF_CTRL, 1'b1, 32'h1);
            apb(OFF_ACTIVE, 1'b0, 0);
            chk(q, cfg);
            prevAct = cfg;
            settle(8);
            base = cmdPos;
            bCw = cntCw;
            bCcw = cntCcw;
            k = m <= 2 ? 0 : (m <= 4 ? 1 : 2);
            d = m == 6 ? 2 : (m == 7 ? 4 : 1);
            spc_pulse_gen_inst.unit(k, 1'b1);
            spc_pulse_gen_inst.unit(k, 1'b1);
            spc_pulse_gen_inst.unit(k, 1'b0);
            settle(8);
            chk(cmdPos - base, d);
            chk(cntCw - bCw, m[0] ? 2 * d : d);
            chk(cntCcw - bCcw, m[0] ? d : 2 * d);
        end
        apb(OFF_CFG, 1'b1, 32'h40);
        apb(OFF_CTRL, 1'b1, 32'h1);
        modeSwitch <= 1'b1;
        base = cmdPos;
        spc_pulse_gen_inst.unit(1, 1'b1);
        settle(8);
        chk(cmdPos - base, 32'h1);
        @(posedge mclk) currentOn <= 1'b1;
        settle(5);
        chk({exciteEn, exciteAtZero}, 2'b10);
        @(posedge mclk) currentOn <= 1'b0;
        apb(OFF_CFG, 1'b1, 32'h50);
        apb(OFF_CTRL, 1'b1, 32'h1);
        currentOn <= 1'b1;
        rotorAtZero <= 1'b1;
        settle(5);
        chk({exciteEn, exciteAtZero, elZero}, 3'b111);
        @(posedge mclk) currentOn <= 1'b0;
        apb(OFF_CFG, 1'b1, 32'h48);
        apb(OFF_CTRL, 1'b1, 32'h1);
        settle(5);
        chk({exciteEn, exciteAtZero}, 2'b11);
        @(posedge mclk) freeIn <= 1'b1;
        settle(4);
        chk(exciteEn, 1'b0);
        @(posedge mclk) freeIn <= 1'b0;
        settle(4);
        chk(autoReturn, 1'b0);
        apb(OFF_CFG, 1'b1, 32'h60);
        apb(OFF_CTRL, 1'b1, 32'h1);
        settle(4);
        chk(autoReturn, 1'b1);
        @(posedge mclk) deviationZero <= 1'b1;
        settle(4);
        chk(autoReturn, 1'b0);
        @(posedge mclk) deviationZero <= 1'b0;
        currentOn <= 1'b1;
        settle(4);
        chk(autoReturn, 1'b1);
        @(posedge mclk) freeIn <= 1'b1;
        settle(4);
        @(posedge mclk) freeIn <= 1'b0;
        settle(4);
        chk(autoReturn, 1'b1);
        close_out();
    end

    initial
    begin
        repeat (30000) @(posedge mclk);
        n_mismatch++;
        close_out();
    end
endmodule // test_spc_decoder
